// ---- pkg/mctcc_pkg.sv ----
// constants and types shared by the capture/compare channel block
package mctcc_pkg;
    localparam int NCH   = 4;
    localparam int VAL_W = 16;

    // word indices on adr_i[5:2]; byte address is four times the index
    localparam logic [3:0] IDX_CTL0 = 4'h0;
    localparam logic [3:0] IDX_VAL0 = 4'h4;
    localparam logic [3:0] IDX_STAT = 4'h8;
    localparam logic [3:0] IDX_MASK = 4'h9;

    // control register fields
    localparam int CTL_EN    = 0;
    localparam int CTL_MODE  = 1;
    localparam int CTL_POL   = 3;
    localparam int CTL_CEDGE = 4;
    localparam int CTL_CSRC  = 5;

    localparam logic [VAL_W-1:0] VAL_RST  = 16'h0000;
    localparam logic [VAL_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [VAL_W-1:0] CNT_ONE  = 16'h0001;
    localparam logic [31:0]      DAT_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        MCTCC_ONESHOT = 2'b00,
        MCTCC_CONT    = 2'b01,
        MCTCC_PWM     = 2'b10,
        MCTCC_CAPT    = 2'b11
    } mctcc_mode_e;
endpackage

// ---- pkg/mctcc_edge_if.sv ----
// synchronised pin edges passed from the input stage to the channel core
`timescale 1ns/10ps
interface mctcc_edge_if;
    logic [3:0] rise;
    logic [3:0] fall;
    modport src (output rise, output fall);
    modport dst (input rise, input fall);
endinterface

// ---- core/mctcc_sync.sv ----
// two-flop pin synchroniser with rising and falling edge detect
`timescale 1ns/10ps
module mctcc_sync
    import mctcc_pkg::*;
(
    input  wire logic     clk_i,
    input  wire logic     rst_i,
    input  wire logic [3:0] pin_i,
    mctcc_edge_if.src     edge_o
);
    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
    } mctcc_sync_s;

    mctcc_sync_s st;
    mctcc_sync_s next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = pin_i;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // edges look only at the second and third stage
    assign edge_o.rise = st.s2 & ~st.s3;
    assign edge_o.fall = ~st.s2 & st.s3;
endmodule

// ---- core/mctcc_top.sv ----
// four capture/compare channels beside a shared 16-bit counter
`timescale 1ns/10ps
module mctcc_top
    import mctcc_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [5:2]        adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    input  wire logic [VAL_W-1:0]  count_i,
    input  wire logic              cnt_tick_i,
    input  wire logic              cnt_run_i,
    input  wire logic              cnt_updown_i,
    input  wire logic [VAL_W-1:0]  reload_i,
    input  wire logic [NCH-1:0]    timer_four_pin_i,
    output logic      [NCH-1:0]    timer_four_pin_o,
    output logic      [NCH-1:0]    timer_four_pin_oe_o,
    input  wire logic [NCH-1:0]    event_i,
    output logic      [NCH-1:0]    event_o,
    output logic                   irq_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NCH-1:0][VAL_W-1:0] val;
        logic [NCH-1:0][VAL_W-1:0] buff;
        logic [NCH-1:0]            pend;
        logic [NCH-1:0]            unit_enable;
        logic [NCH-1:0][1:0]       mode;
        logic [NCH-1:0]            output_polarity;
        logic [NCH-1:0]            cedge;
        logic [NCH-1:0]            csrc;
        logic [NCH-1:0]            pin;
        logic [NCH-1:0]            oe;
        logic [NCH-1:0]            evt;
        logic [NCH-1:0]            match_event_flag;
        logic [NCH-1:0]            mask;
        logic [VAL_W-1:0]          prev_cnt;
        logic                      ack;
        logic [31:0]               dat;
    } mctcc_state_s;

    mctcc_state_s st;
    mctcc_state_s next_st;

    logic [NCH-1:0] hit;
    logic [NCH-1:0] cap;
    logic [NCH-1:0] wr_ctl;
    logic [NCH-1:0] wr_val;
    logic           wr;
    logic           wr_stat;
    logic           eoc;

    mctcc_edge_if edges ();

    mctcc_sync u_sync (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pin_i  (timer_four_pin_i),
        .edge_o (edges)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic idx_is(input logic [3:0] adr, input logic [3:0] base,
                                    input int ch);
        return adr == (base + ch[3:0]);
    endfunction

    function automatic logic [31:0] read_mux(input mctcc_state_s s, input logic [3:0] adr);
        logic [31:0] r;
        r = DAT_ZERO;
        for (int c = 0; c < NCH; c++) begin
            if (idx_is(adr, IDX_CTL0, c)) begin
                r[CTL_EN]           = s.unit_enable[c];
                r[CTL_MODE +: 2]    = s.mode[c];
                r[CTL_POL]          = s.output_polarity[c];
                r[CTL_CEDGE]        = s.cedge[c];
                r[CTL_CSRC]         = s.csrc[c];
            end
            if (idx_is(adr, IDX_VAL0, c)) begin
                r[VAL_W-1:0] = s.val[c];
            end
        end
        if (adr == IDX_STAT) begin
            r[NCH-1:0] = s.match_event_flag;
        end
        if (adr == IDX_MASK) begin
            r[NCH-1:0] = s.mask;
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        hit     = '0;
        cap     = '0;
        wr_ctl  = '0;
        wr_val  = '0;

        // bus: ack one cycle after the request, write at the ack edge
        next_st.ack = cyc_i && stb_i && !st.ack;
        next_st.dat = read_mux(st, adr_i);
        wr          = cyc_i && stb_i && we_i && st.ack;
        wr_stat     = wr && (adr_i == IDX_STAT) && sel_i[0];

        // end of counting cycle
        eoc = cnt_tick_i && (count_i == CNT_ZERO) &&
              (cnt_updown_i ? (st.prev_cnt == CNT_ONE) : (st.prev_cnt == reload_i));
        if (cnt_tick_i) begin
            next_st.prev_cnt = count_i;
        end

        if (wr && (adr_i == IDX_MASK) && sel_i[0]) begin
            next_st.mask = dat_i[NCH-1:0];
        end

        for (int i = 0; i < NCH; i++) begin
            wr_ctl[i] = wr && idx_is(adr_i, IDX_CTL0, i) && sel_i[0];
            wr_val[i] = wr && idx_is(adr_i, IDX_VAL0, i) && (sel_i[1:0] == 2'b11);

            if (wr_ctl[i]) begin
                next_st.unit_enable[i]     = dat_i[CTL_EN];
                next_st.mode[i]            = dat_i[CTL_MODE +: 2];
                next_st.output_polarity[i] = dat_i[CTL_POL];
                next_st.cedge[i]           = dat_i[CTL_CEDGE];
                next_st.csrc[i]            = dat_i[CTL_CSRC];
            end

            // compare match and capture event
            hit[i] = st.unit_enable[i] && cnt_tick_i &&
                     (st.mode[i] != MCTCC_CAPT) && (count_i == st.val[i]);
            cap[i] = st.unit_enable[i] && (st.mode[i] == MCTCC_CAPT) &&
                     (st.csrc[i] ? event_i[i]
                                 : (st.cedge[i] ? edges.fall[i] : edges.rise[i]));

            // value register: buffered while running
            if (eoc && st.pend[i]) begin
                next_st.val[i]  = st.buff[i];
                next_st.pend[i] = 1'b0;
            end
            if (wr_val[i]) begin
                if (cnt_run_i) begin
                    next_st.buff[i] = dat_i[VAL_W-1:0];
                    next_st.pend[i] = 1'b1;
                end else begin
                    next_st.val[i]  = dat_i[VAL_W-1:0];
                    next_st.pend[i] = 1'b0;
                end
            end
            if (cap[i]) begin
                next_st.val[i] = count_i;
            end

            // one-shot disables itself; counter is not touched
            if (hit[i] && (st.mode[i] == MCTCC_ONESHOT)) begin
                next_st.unit_enable[i] = 1'b0;
            end

            // event line and sticky flag; set wins over clear
            next_st.evt[i] = hit[i] || cap[i];
            if (wr_stat && dat_i[i]) begin
                next_st.match_event_flag[i] = 1'b0;
            end
            if (hit[i] || cap[i]) begin
                next_st.match_event_flag[i] = 1'b1;
            end

            // output pin
            next_st.oe[i] = (next_st.mode[i] != MCTCC_CAPT);
            if (st.mode[i] == MCTCC_PWM && st.unit_enable[i]) begin
                if (hit[i]) begin
                    next_st.pin[i] = ~st.pin[i];
                end
            end else if (hit[i]) begin
                next_st.pin[i] = ~st.output_polarity[i];
            end else begin
                next_st.pin[i] = next_st.output_polarity[i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign dat_o               = st.dat;
    assign ack_o               = st.ack;
    assign timer_four_pin_o    = st.pin;
    assign timer_four_pin_oe_o = st.oe;
    assign event_o             = st.evt;
    assign irq_o               = |(st.match_event_flag & st.mask);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ------------------------------------------------------------
    // channel checks
    // ------------------------------------------------------------

    for (genvar g = 0; g < NCH; g++) begin : g_chk
        AST_OS_OFF: assert property (
            hit[g] && st.mode[g] == MCTCC_ONESHOT && !wr_ctl[g] |=> !st.unit_enable[g]
        ) else $error("one-shot channel still enabled after match");

        AST_OS_PULSE: assert property (
            hit[g] && st.mode[g] == MCTCC_ONESHOT && !wr_ctl[g]
            |=> timer_four_pin_o[g] == ~st.output_polarity[g]
            ##1 timer_four_pin_o[g] == st.output_polarity[g]
        ) else $error("one-shot pulse not one clock wide");

        AST_CONT_ON: assert property (
            hit[g] && st.mode[g] == MCTCC_CONT && !wr_ctl[g] |=> st.unit_enable[g]
        ) else $error("continuous channel lost enable on match");

        AST_CONT_PULSE: assert property (
            hit[g] && st.mode[g] == MCTCC_CONT
            |=> timer_four_pin_o[g] == ~$past(st.output_polarity[g])
        ) else $error("continuous match gave no pulse");

        AST_PWM_TGL: assert property (
            hit[g] && st.mode[g] == MCTCC_PWM |=> timer_four_pin_o[g] != $past(timer_four_pin_o[g])
        ) else $error("pwm output did not toggle");

        AST_FLAG_SET: assert property (
            hit[g] || cap[g] |=> st.match_event_flag[g] && event_o[g]
        ) else $error("event did not set flag and event line");

        AST_FLAG_HOLD: assert property (
            st.match_event_flag[g] && !(wr_stat && dat_i[g]) |=> st.match_event_flag[g]
        ) else $error("event flag dropped without clear");

        AST_CAPT: assert property (
            cap[g] |=> st.val[g] == $past(count_i)
        ) else $error("capture did not load count");

        AST_EOC_LOAD: assert property (
            eoc && st.pend[g] && !cap[g] && !wr_val[g]
            |=> st.val[g] == $past(st.buff[g]) && !st.pend[g]
        ) else $error("buffered value not applied at cycle end");

        AST_RUN_HOLD: assert property (
            wr_val[g] && cnt_run_i && !eoc && !cap[g] |=> st.val[g] == $past(st.val[g])
        ) else $error("value changed at once while running");

        AST_RUN_BUF: assert property (
            wr_val[g] && cnt_run_i
            |=> st.pend[g] && st.buff[g] == $past(dat_i[VAL_W-1:0])
        ) else $error("running value write not held in buffer");

        AST_PEND_KEEP: assert property (
            st.pend[g] && !eoc && !wr_val[g] |=> st.pend[g]
        ) else $error("buffered value dropped before cycle end");

        AST_STOP_LOAD: assert property (
            wr_val[g] && !cnt_run_i && !cap[g]
            |=> st.val[g] == $past(dat_i[VAL_W-1:0])
        ) else $error("stopped value write not applied at once");

        AST_MODE_WR: assert property (
            wr_ctl[g] |=> st.mode[g] == $past(dat_i[CTL_MODE +: 2])
        ) else $error("mode field not taken from control write");

        AST_CONT_BACK: assert property (
            hit[g] && st.mode[g] == MCTCC_CONT && !wr_ctl[g] ##1 !hit[g]
            |=> timer_four_pin_o[g] == st.output_polarity[g]
        ) else $error("continuous pulse did not return to idle");

        AST_PWM_HOLD: assert property (
            st.mode[g] == MCTCC_PWM && st.unit_enable[g] && !hit[g]
            |=> $stable(timer_four_pin_o[g])
        ) else $error("pwm output moved without a match");

        AST_OE_CAPT: assert property (
            st.mode[g] == MCTCC_CAPT |-> !timer_four_pin_oe_o[g]
        ) else $error("capture channel drives its pin");

        AST_EVT_SRC: assert property (
            event_o[g] |-> $past(hit[g] || cap[g])
        ) else $error("event line pulsed without match or capture");

        AST_FLAG_CLR: assert property (
            wr_stat && dat_i[g] && !hit[g] && !cap[g] |=> !st.match_event_flag[g]
        ) else $error("event flag not cleared by write of one");

        AST_OFF_QUIET: assert property (
            !st.unit_enable[g] |=> !event_o[g]
        ) else $error("disabled channel raised an event");
    end

    // ------------------------------------------------------------
    // bus and interrupt checks
    // ------------------------------------------------------------
    AST_IRQ: assert property (
        |(hit & st.mask) && !wr |=> irq_o
    ) else $error("unmasked match without interrupt");

    AST_ACK_ONE: assert property (
        ack_o |=> !ack_o
    ) else $error("ack held more than one cycle");

    AST_ACK_REQ: assert property (
        ack_o |-> $past(cyc_i) && $past(stb_i)
    ) else $error("ack without a request");

    AST_RD_HIGH: assert property (
        ack_o |-> dat_o[31:VAL_W] == '0
    ) else $error("upper read data bits not zero");

    AST_SEL_GATE: assert property (
        wr && !sel_i[0] |=> st.mask == $past(st.mask)
    ) else $error("mask written without its byte enable");

    COV_OS:   cover property (hit[0] && st.mode[0] == MCTCC_ONESHOT);
    COV_CONT: cover property (hit[1] && st.mode[1] == MCTCC_CONT);
    COV_PWM:  cover property (hit[1] && st.mode[1] == MCTCC_PWM ##[1:200] hit[1]);
    COV_CAPT: cover property (cap[2]);
    COV_EOC:  cover property (eoc && |st.pend);
endmodule

// ---- testbench/mctcc_far_model.sv ----
// far-side model: channel pins and event-system lines
`timescale 1ns/10ps
module mctcc_far_model
    import mctcc_pkg::*;
(
    input  wire logic [NCH-1:0] pin_o_i,
    input  wire logic [NCH-1:0] pin_oe_i,
    input  wire logic [NCH-1:0] ext_pin_i,
    input  wire logic [NCH-1:0] ext_evt_i,
    output logic      [NCH-1:0] pin_i_o,
    output logic      [NCH-1:0] event_o
);
    // a driven pin reads back its own level, a released one the outside level
    assign pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_pin_i);
    assign event_o = ext_evt_i;
endmodule

// ---- testbench/mctcc_top_tb.sv ----
// self-checking bench for the capture/compare channel block
`timescale 1ns/10ps
module mctcc_top_tb;
    import mctcc_pkg::*;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic        cnt_tick_i = 0, cnt_run_i = 0, cnt_updown_i = 0, ack_o, irq_o;
    logic [3:0]  adr_i = 0, sel_i = 4'hF, ext_pin = 0, ext_evt = 0;
    logic [3:0]  pin_in, evt_in, pin_out, pin_oe, ev_out;
    logic [31:0] dat_i = 0, dat_o, rd;
    logic [15:0] count_i = 0, reload_i = 16'hFFFF, nv, cv;
    logic [15:0] r [4];
    int          n_fail = 0, n_compared = 0, cycles = 0, seed = 32'h1f92df8c, k;

    always #2.5 clk_i = ~clk_i;

    mctcc_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .count_i(count_i), .cnt_tick_i(cnt_tick_i), .cnt_run_i(cnt_run_i),
        .cnt_updown_i(cnt_updown_i), .reload_i(reload_i), .timer_four_pin_i(pin_in),
        .timer_four_pin_o(pin_out), .timer_four_pin_oe_o(pin_oe), .event_i(evt_in),
        .event_o(ev_out), .irq_o(irq_o));

    mctcc_far_model far (.pin_o_i(pin_out), .pin_oe_i(pin_oe), .ext_pin_i(ext_pin),
        .ext_evt_i(ext_evt), .pin_i_o(pin_in), .event_o(evt_in));

    // ----------------------------------------
    // tasks and expectation helpers
    // ----------------------------------------
    task finish_test;
        if (n_fail == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task chk_b(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %b seen %b", nm, e, g);
        end
    endtask

    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk_i);
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            t++;
        end while (ack_o !== 1'b1 && t < 50);
        if (t >= 50)
            n_fail++;
        rd = dat_o;
        cyc_i <= 0;
        stb_i <= 0;
    endtask

    task rdchk(input string nm, input logic [3:0] a, input logic [31:0] e);
        wb(0, a, DAT_ZERO);
        chk_w(nm, e, rd);
    endtask

    task nxt;
        @(posedge clk_i);
        #1;
    endtask

    // move the outside pin level and wait for the capture event
    task pin_capt(input int ch, input logic lvl);
        cv = 16'($random(seed));
        @(posedge clk_i);
        count_i <= cv;
        ext_pin[ch] <= lvl;
        k = 0;
        do begin
            nxt;
            k++;
        end while (ev_out[ch] !== 1'b1 && k < 8);
    endtask

    // one counter step, then the outputs of the cycle after it
    task match(input int ch, input logic [15:0] v, input logic ev, input logic pin);
        @(posedge clk_i);
        count_i <= v;
        cnt_tick_i <= 1;
        @(posedge clk_i);
        cnt_tick_i <= 0;
        #1;
        chk_b("event_o", ev, ev_out[ch]);
        chk_b("pin_o", pin, pin_out[ch]);
    endtask

    function automatic logic [31:0] ctl(logic en, logic [1:0] m, logic pol, logic src);
        return {26'h0, src, 1'b0, pol, m, en};
    endfunction

    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 5000) begin
            n_fail++;
            finish_test;
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        reload_i <= 16'h8000 | 16'($random(seed));
        rdchk("control", IDX_CTL0, DAT_ZERO);
        rdchk("status", IDX_STAT, DAT_ZERO);
        chk_b("irq_o", 1'b0, irq_o);
        chk_b("pin_oe", 1'b1, pin_oe[1]);
        for (k = 0; k < 4; k++) begin
            r[k] = 16'h1000 + 16'($random(seed) & 32'hFFF);
            wb(1, 4'(IDX_VAL0 + k), {16'h0, r[k]});
            rdchk("value", 4'(IDX_VAL0 + k), {16'h0, r[k]});
        end
        wb(1, 4'hA, 32'hFFFF_FFFF);
        rdchk("unmapped", 4'hA, DAT_ZERO);
        sel_i <= 4'h2;
        wb(1, IDX_MASK, 32'hF);
        sel_i <= 4'h1;
        wb(1, 4'h4, 32'h0000_FFFF);
        sel_i <= 4'hF;
        rdchk("mask", IDX_MASK, DAT_ZERO);
        rdchk("value", 4'h4, {16'h0, r[0]});
        wb(1, IDX_MASK, 32'hF);
        wb(1, 4'h0, ctl(1, MCTCC_ONESHOT, 0, 0));
        match(0, r[0], 1, 1);
        chk_b("irq_o", 1'b1, irq_o);
        nxt;
        chk_b("pin_o", 1'b0, pin_out[0]);
        chk_b("event_o", 1'b0, ev_out[0]);
        rdchk("control", 4'h0, ctl(0, MCTCC_ONESHOT, 0, 0));
        match(0, r[0], 0, 0);
        wb(1, IDX_STAT, DAT_ZERO);
        rdchk("status", IDX_STAT, 32'h1);
        wb(1, IDX_MASK, DAT_ZERO);
        #1 chk_b("irq_o", 1'b0, irq_o);
        wb(1, IDX_MASK, 32'hF);
        #1 chk_b("irq_o", 1'b1, irq_o);
        wb(1, IDX_STAT, 32'h1);
        #1 chk_b("irq_o", 1'b0, irq_o);
        wb(1, 4'h1, ctl(0, MCTCC_CONT, 1, 0));
        wb(1, 4'h1, ctl(1, MCTCC_CONT, 1, 0));
        for (k = 0; k < 2; k++) begin
            match(1, r[1], 1, 0);
            nxt;
            chk_b("pin_o", 1'b1, pin_out[1]);
        end
        rdchk("control", 4'h1, ctl(1, MCTCC_CONT, 1, 0));
        rdchk("status", IDX_STAT, 32'h2);
        wb(1, 4'h2, ctl(1, MCTCC_PWM, 0, 0));
        for (k = 0; k < 4; k++)
            match(2, r[2], 1, ~k[0]);
        match(2, r[2] ^ 16'h0001, 0, 0);
        rdchk("status", IDX_STAT, 32'h6);
        wb(1, 4'h3, ctl(1, MCTCC_CONT, 0, 0));
        cnt_run_i <= 1;
        nv = r[3] ^ 16'h0101;
        wb(1, 4'h7, {16'h0, nv});
        match(3, nv, 0, 0);
        match(3, r[3], 1, 1);
        match(3, reload_i, 0, 0);
        match(3, CNT_ZERO, 0, 0);
        match(3, nv, 1, 1);
        cnt_updown_i <= 1;
        wb(1, 4'h7, {16'h0, r[3]});
        match(3, r[3], 0, 0);
        match(3, CNT_ONE, 0, 0);
        match(3, CNT_ZERO, 0, 0);
        match(3, r[3], 1, 1);
        cnt_run_i <= 0;
        wb(1, IDX_STAT, 32'hF);
        wb(1, 4'h0, ctl(1, MCTCC_CAPT, 0, 1));
        nxt;
        chk_b("pin_oe", 1'b0, pin_oe[0]);
        cv = 16'($random(seed));
        @(posedge clk_i);
        count_i <= cv;
        ext_evt[0] <= 1;
        @(posedge clk_i);
        ext_evt[0] <= 0;
        #1 chk_b("event_o", 1'b1, ev_out[0]);
        rdchk("value", 4'h4, {16'h0, cv});
        rdchk("status", IDX_STAT, 32'h1);
        wb(1, 4'h1, ctl(1, MCTCC_CAPT, 0, 0));
        repeat (6) nxt;
        pin_capt(1, 1'b1);
        chk_b("event_o", 1'b1, ev_out[1]);
        rdchk("value", 4'h5, {16'h0, cv});
        ext_pin[2] <= 1;
        wb(1, 4'h2, ctl(1, MCTCC_CAPT, 0, 0) | 32'h10);
        repeat (6) nxt;
        pin_capt(2, 1'b0);
        chk_b("event_o", 1'b1, ev_out[2]);
        rdchk("value", 4'h6, {16'h0, cv});
        @(posedge clk_i);
        rst_i <= 1;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        rdchk("status", IDX_STAT, DAT_ZERO);
        rdchk("control", 4'h1, DAT_ZERO);
        rdchk("value", 4'h5, DAT_ZERO);
        chk_b("irq_o", 1'b0, irq_o);
        finish_test;
    end
endmodule
